//--- design/cfg_mem_pkg.sv
// Shared constants for the serial configuration memory read-out
package cfg_mem_pkg;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W        = 21;  // Largest variant: 2,097,152 x 1
  localparam int unsigned CNT_W         = 22;  // Counter can reach the depth itself
  localparam int unsigned SIZE_SEL_W    = 3;
  localparam int unsigned SMALLEST_LOG2 = 16;  // Smallest variant: 65,536 x 1
  localparam int unsigned LARGEST_SEL   = 5;
  localparam int unsigned LOW_BLOCK_LOG2 = 12; // Block shielded by the block-protect pin

  // ----------------------------------------------------------------
  // Timing and reset values
  // ----------------------------------------------------------------
  localparam int unsigned POR_CYCLES    = 16;  // Power-on reset cycle length
  localparam int unsigned POR_CNT_W     = 5;
  localparam int unsigned CLK_HALF      = 2;   // Master bit clock half period, ref cycles
  localparam int unsigned DIV_W         = 2;
  localparam int unsigned SYNC_N        = 7;   // Pins passing the two-stage synchroniser
  localparam logic        CASCADE_IDLE  = 1'b1;

  // Synchroniser lane positions
  localparam int unsigned LN_CS    = 0;
  localparam int unsigned LN_ROE   = 1;
  localparam int unsigned LN_BCLK  = 2;
  localparam int unsigned LN_SMODE = 3;
  localparam int unsigned LN_PSEL  = 4;
  localparam int unsigned LN_PP    = 5;
  localparam int unsigned LN_BP    = 6;

endpackage : cfg_mem_pkg

//--- design/config_bit_array.sv
// One-bit-wide storage array with asynchronous read and clocked write
`timescale 1ns/1ps
`default_nettype none
module config_bit_array
  import cfg_mem_pkg::*;
(
  // Clock
  input  wire logic              ref_clk,
  // Write side
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic              wr_bit,
  // Read side
  input  wire logic [ADDR_W-1:0] rd_addr,
  output logic                   rd_bit
);

  logic bits_r [0:(1 << ADDR_W)-1];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      bits_r[wr_addr] <= wr_bit;
    end
  end

  assign rd_bit = bits_r[rd_addr];

endmodule : config_bit_array
`default_nettype wire

//--- design/serial_config_memory_readout.sv
// Read-out, cascade and programming gate of a serial configuration memory
//
// Contract
// R1: Reset level on reset/output-enable clears address counter and floats data.
// R2: Chip select high after reset freezes counter and floats data.
// R3: Chip select low with enable level enables counter and data driver.
// R4: After all bits sent and cascade low, data pin is released.
// R5: Power-up clears the address counter with no external pulse.
// R6: Rising bit clock advances counter only when enabled, selected, data remaining.
// R7: Master with counting blocked drives its bit clock pin low.
// R8: Reset level stops the oscillator and holds the clock pin low.
// R9: Reset/output-enable polarity is chosen by stored configuration bits.
// R10: Portion protect only blocks programming writes; inactive when undriven.
// R11: Programming with select low: block-protect high refuses lowest block writes.
// R12: Chip select sampled at reset picks master or follower role.
// R13: Cascade output goes low once counter reaches its maximum.
// R14: Programming accepted only while the device-select input selects it.
// R15: Ready indicator held low during power-on reset, then released.
// R16: Programming-mode input low switches to two-wire programming mode.
// R17: Data pin three-state while loading, open-collector while programming.
// R18: Array is one bit wide; depth selectable, counter spans that depth.
// R19: Edge after final bit drives cascade low and disables data driver.
// R20: Chip select high means standby with data floating, whatever reset does.
// R21: Counter holds at its maximum until reset or power-up clears it.
`timescale 1ns/1ps
`default_nettype none
module serial_config_memory_readout
  import cfg_mem_pkg::*;
(
  // Clock and power-on reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Configuration straps
  input  wire logic                  oe_active_high,
  input  wire logic [SIZE_SEL_W-1:0] size_sel,
  // Control pins
  input  wire logic                  chip_select_low,
  input  wire logic                  reset_oe_in,
  input  wire logic                  program_mode_select_low,
  input  wire logic                  program_select_in,
  input  wire logic                  portion_protect_in,
  input  wire logic                  block_protect_in,
  // Bit clock pin
  input  wire logic                  serial_bit_clock_in,
  output logic                       serial_bit_clock_out,
  output logic                       serial_bit_clock_oe,
  // Data pin
  input  wire logic                  data_in,
  output logic                       data_out,
  output logic                       data_oe,
  // Cascade and ready
  output logic                       cascade_out_low,
  output logic                       ready_out,
  output logic                       ready_oe,
  // Programming engine side
  input  wire logic                  prog_drive_low,
  input  wire logic                  prog_wr_en,
  input  wire logic [ADDR_W-1:0]     prog_wr_addr,
  input  wire logic                  prog_wr_bit,
  output logic                       prog_data_in,
  output logic                       prog_wr_done,
  output logic                       prog_wr_refused
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [SYNC_N-1:0] pin_raw;
  logic [SYNC_N-1:0] pin_s1_r;
  logic [SYNC_N-1:0] pin_s2_r;
  logic              bclk_s3_r;
  logic              din_s1_r;

  assign pin_raw = {block_protect_in, portion_protect_in, program_select_in,
                    program_mode_select_low, serial_bit_clock_in, reset_oe_in,
                    chip_select_low};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_N; gi = gi + 1) begin : g_sync
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pin_s1_r[gi] <= 1'b0;
          pin_s2_r[gi] <= 1'b0;
        end else begin
          pin_s1_r[gi] <= pin_raw[gi];
          pin_s2_r[gi] <= pin_s1_r[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bclk_s3_r    <= 1'b0;
      din_s1_r     <= 1'b0;
      prog_data_in <= 1'b0;
    end else begin
      bclk_s3_r    <= pin_s2_r[LN_BCLK];
      din_s1_r     <= data_in;
      prog_data_in <= din_s1_r;
    end
  end

  logic cs_high;
  logic reset_level;
  logic prog_mode;

  assign cs_high     = pin_s2_r[LN_CS];
  // Stored polarity decides which level means reset
  assign reset_level = oe_active_high ? ~pin_s2_r[LN_ROE] : pin_s2_r[LN_ROE];  // see R9
  assign prog_mode   = ~pin_s2_r[LN_SMODE];  // see R16

  // ----------------------------------------------------------------
  // Power-on reset and ready
  // ----------------------------------------------------------------
  logic [POR_CNT_W-1:0] por_cnt_r;
  logic                 por_done_r;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      por_cnt_r  <= '0;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r  <= por_cnt_r + 1'b1;
      por_done_r <= (por_cnt_r == POR_CNT_W'(POR_CYCLES - 1));
    end
  end

  // Open collector: only ever pulls low
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ready_out <= 1'b0;
      ready_oe  <= 1'b1;
    end else begin
      ready_out <= 1'b0;
      ready_oe  <= ~por_done_r;  // see R15
    end
  end

  // ----------------------------------------------------------------
  // Chain role
  // ----------------------------------------------------------------
  logic master_r;

  // Role follows chip select for as long as a reset is in force
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      master_r <= 1'b0;
    end else if (!por_done_r || reset_level) begin
      master_r <= ~cs_high;  // see R12
    end
  end

  // ----------------------------------------------------------------
  // Depth selection
  // ----------------------------------------------------------------
  logic [CNT_W-1:0] depth;

  always_comb begin
    if (size_sel > SIZE_SEL_W'(LARGEST_SEL)) begin
      depth = CNT_W'(1) << ADDR_W;
    end else begin
      depth = CNT_W'(1) << (SMALLEST_LOG2 + 32'(size_sel));  // see R18
    end
  end

  // ----------------------------------------------------------------
  // Bit clock: internal divider or synchronised pin
  // ----------------------------------------------------------------
  logic             enabled;
  logic [DIV_W-1:0] div_r;
  logic             bclk_r;
  logic             master_rise;
  logic             follow_rise;
  logic             adv;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic             hit_end;

  assign enabled = por_done_r & ~reset_level & ~cs_high & cascade_out_low & ~prog_mode;
  // Step one cycle after bclk_r rises, on the edge the pin rises, so the far side still latches the current bit
  assign master_rise = master_r & enabled & bclk_r & (div_r == '0);
  assign follow_rise = ~master_r & pin_s2_r[LN_BCLK] & ~bclk_s3_r;
  assign adv         = enabled & (master_rise | follow_rise);  // see R6
  assign cnt_nxt     = cnt_r + 1'b1;
  assign hit_end     = adv & (cnt_nxt == depth);

  // Oscillator halts and pin sits low whenever counting is blocked
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !(master_r && enabled)) begin
      div_r  <= '0;
      bclk_r <= 1'b0;  // see R7, R8
    end else if (div_r == DIV_W'(CLK_HALF - 1)) begin
      div_r  <= '0;
      bclk_r <= ~bclk_r;
    end else begin
      div_r  <= div_r + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      serial_bit_clock_out <= 1'b0;
      serial_bit_clock_oe  <= 1'b0;
    end else begin
      serial_bit_clock_out <= bclk_r;
      serial_bit_clock_oe  <= master_r;  // see R7
    end
  end

  // ----------------------------------------------------------------
  // Address counter and cascade
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !por_done_r || reset_level) begin
      cnt_r           <= '0;  // see R1, R5
      cascade_out_low <= CASCADE_IDLE;
    end else if (adv) begin
      cnt_r <= cnt_nxt;
      // Counter parks at the depth: no wrap back into a finished image
      if (hit_end) begin
        cascade_out_low <= 1'b0;  // see R13, R19, R21
      end
    end
  end

  // ----------------------------------------------------------------
  // Array and data pin
  // ----------------------------------------------------------------
  logic rd_bit;
  logic wr_ok;
  logic wr_hit_low;
  logic wr_hit_portion;

  config_bit_array u_array (
    .ref_clk (ref_clk),
    .wr_en   (wr_ok),
    .wr_addr (prog_wr_addr),
    .wr_bit  (prog_wr_bit),
    .rd_addr (cnt_r[ADDR_W-1:0]),
    .rd_bit  (rd_bit)
  );

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      data_out <= 1'b0;
      data_oe  <= 1'b0;
    end else if (prog_mode) begin
      data_out <= 1'b0;
      data_oe  <= prog_drive_low & ~cs_high & pin_s2_r[LN_PSEL];  // see R17, R14
    end else begin
      data_out <= rd_bit;
      // Dropped on the final edge so the next memory meets a free line
      data_oe  <= enabled & ~hit_end;  // see R1, R2, R3, R4, R20
    end
  end

  // ----------------------------------------------------------------
  // Programming write gate
  // ----------------------------------------------------------------
  // Portion protect guards the top quarter; unused while loading
  assign wr_hit_low     = (prog_wr_addr >> LOW_BLOCK_LOG2) == '0;
  assign wr_hit_portion = prog_wr_addr >= ADDR_W'((depth >> 2) * 3);
  assign wr_ok = prog_wr_en & prog_mode & ~cs_high & pin_s2_r[LN_PSEL]           // see R14
               & ~(pin_s2_r[LN_BP] & wr_hit_low)                                 // see R11
               & ~(pin_s2_r[LN_PP] & wr_hit_portion);                            // see R10

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      prog_wr_done    <= 1'b0;
      prog_wr_refused <= 1'b0;
    end else begin
      prog_wr_done    <= wr_ok;
      prog_wr_refused <= prog_wr_en & ~wr_ok;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_last_edge;
    hit_end;
  endsequence

  sequence s_released;
    !cascade_out_low && !data_oe ##1 !data_oe;
  endsequence

  a_reset_clears: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R1
    reset_level && !prog_mode |=> cnt_r == '0 && !data_oe)
    else $error("reset level did not clear counter or float data");

  a_standby_float: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R20
    cs_high && !prog_mode |=> !data_oe)
    else $error("data driven while deselected");

  a_enable_drive: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R3
    enabled && !hit_end |=> data_oe)
    else $error("data not driven while enabled");

  a_advance_step: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R6
    adv && !reset_level |=> cnt_r == $past(cnt_r) + 1'b1)
    else $error("counter did not step by one");

  a_cascade_end: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R19
    s_last_edge |=> s_released)
    else $error("final edge did not hand over the line");

  a_hold_max: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R21
    !cascade_out_low && !reset_level |=> $stable(cnt_r))
    else $error("counter moved past its maximum");

  a_osc_stop: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R8
    master_r && reset_level[*2] |=> !serial_bit_clock_out && serial_bit_clock_oe)
    else $error("master clock pin not held low in reset");

  a_ready_por: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R15
    !por_done_r |=> ready_oe && !ready_out)
    else $error("ready released during power-on reset");

  a_block_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R11
    prog_wr_en && pin_s2_r[LN_BP] && wr_hit_low |=> prog_wr_refused && !prog_wr_done)
    else $error("write into protected block accepted");

  a_portion_guard: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R10
    prog_wr_en && pin_s2_r[LN_PP] && wr_hit_portion |=> prog_wr_refused && !prog_wr_done)
    else $error("write into protected portion accepted");

  a_select_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R14
    prog_wr_en && !pin_s2_r[LN_PSEL] |=> prog_wr_refused && !prog_wr_done)
    else $error("write accepted while device not selected");

  a_load_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R16
    prog_wr_en && !prog_mode |=> prog_wr_refused && !prog_wr_done)
    else $error("write accepted outside programming mode");

  a_frozen_count: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R2
    cs_high && !reset_level |=> $stable(cnt_r))
    else $error("counter moved while deselected");

  a_oc_low: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R17
    prog_mode |=> !data_out)
    else $error("data pin driven high in programming mode");

  // Blocked master: oscillator parked, then the pin register follows
  sequence s_master_blocked;
    master_r && !enabled ##1 master_r && !enabled;
  endsequence

  a_master_idle: assert property (@(posedge ref_clk) disable iff (!rst_n)  // see R7
    s_master_blocked |=> !serial_bit_clock_out)
    else $error("blocked master still toggles its clock pin");

endmodule : serial_config_memory_readout
`default_nettype wire

//--- testbench/config_loader_model.sv
// Loader model: follower bit clock source and rising-edge data capture
`timescale 1ns/1ps
`default_nettype none
module config_loader_model (
  // Clock
  input  wire logic       ref_clk,
  // Pins
  input  wire logic       clk_pin,
  input  wire logic       data_pin,
  output var  logic       drv_clk,
  // Capture
  output var  logic [7:0] got,
  output var  logic [7:0] n_got
);
  logic clk_q;
  initial begin
    drv_clk = 1'b0;
    clk_q   = 1'b0;
    got     = 8'h00;
    n_got   = 8'h00;
  end
  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  // Data is taken on the rising pin clock, before the next bit lands
  always @(posedge ref_clk) begin
    clk_q <= clk_pin;
    if (clk_pin && !clk_q) begin
      got   <= {got[6:0], data_pin};
      n_got <= n_got + 8'h01;
    end
  end
  // ----------------------------------------------------------------
  // Follower clock
  // ----------------------------------------------------------------
  // Three cycles a phase, above the one cycle the synchroniser tolerates; stands low after
  task automatic pulse(input int n);
    repeat (n) begin
      drv_clk <= 1'b1;
      repeat (3) @(posedge ref_clk);
      drv_clk <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
  endtask : pulse
endmodule : config_loader_model
`default_nettype wire

//--- testbench/serial_config_memory_readout_test.sv
// Self-checking bench for the serial configuration memory read-out
`timescale 1ns/1ps
`default_nettype none
module serial_config_memory_readout_test;
  import cfg_mem_pkg::*;
  localparam logic [7:0] PAT = 8'hB4;
  logic ref_clk, rst_n, chip_select_low, reset_oe_in, program_mode_select_low;
  logic program_select_in, portion_protect_in, block_protect_in, prog_drive_low;
  logic prog_wr_en, prog_wr_bit, last_d, clk_wire, data_wire, drv_clk;
  logic [ADDR_W-1:0] prog_wr_addr;
  logic oe_active_high;
  logic [SIZE_SEL_W-1:0] size_sel;
  logic serial_bit_clock_out, serial_bit_clock_oe, data_out, data_oe, cascade_out_low;
  logic ready_out, ready_oe, prog_data_in, prog_wr_done, prog_wr_refused;
  logic [7:0] got, n_got;
  int fails, n_tests;
  // ----------------------------------------------------------------
  // Pins and instances
  // ----------------------------------------------------------------
  // Released data line shows the inverse of its last level, not a kind value
  assign data_wire = data_oe ? data_out : ~last_d;
  assign clk_wire  = serial_bit_clock_oe ? serial_bit_clock_out : drv_clk;
  always @(posedge ref_clk) if (data_oe) last_d <= data_out;
  serial_config_memory_readout DUT (.ref_clk, .rst_n, .oe_active_high,
    .size_sel, .chip_select_low, .reset_oe_in, .program_mode_select_low,
    .program_select_in, .portion_protect_in, .block_protect_in,
    .serial_bit_clock_in(clk_wire), .serial_bit_clock_out, .serial_bit_clock_oe,
    .data_in(data_wire), .data_out, .data_oe, .cascade_out_low, .ready_out, .ready_oe,
    .prog_drive_low, .prog_wr_en, .prog_wr_addr, .prog_wr_bit, .prog_data_in,
    .prog_wr_done, .prog_wr_refused);
  config_loader_model u_ldr (.ref_clk, .clk_pin(clk_wire), .data_pin(data_wire),
    .drv_clk, .got, .n_got);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : check
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input int a, input logic b, input logic ok);
    // Lets freshly changed protect and select pins through their synchroniser
    repeat (3) @(posedge ref_clk);
    prog_wr_en   <= 1'b1;
    prog_wr_addr <= a[ADDR_W-1:0];
    prog_wr_bit  <= b;
    @(posedge ref_clk);
    prog_wr_en <= 1'b0;
    #1;
    check("wr_done", {7'h00, ok}, {7'h00, prog_wr_done});
    check("wr_refused", {7'h00, !ok}, {7'h00, prog_wr_refused});
  endtask : wr
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_por();
    int n;
    check("ready_oe_rst", 8'h01, {7'h00, ready_oe});
    @(posedge ref_clk);
    rst_n <= 1'b1;
    n = 0;
    do begin
      cyc(1);
      n++;
      check("cascade_por", 8'h01, {7'h00, cascade_out_low});
    end while (ready_oe !== 1'b0 && n < 40);
    check("por_len", 8'd17, n[7:0]);
    check("ready_out", 8'h00, {7'h00, ready_out});
    $display("test_por done");
  endtask : test_por
  task automatic test_prog();
    for (int i = 0; i < 8; i++) wr(i, PAT[7-i], 1'b1);
    block_protect_in <= 1'b1;
    wr(3, ~PAT[4], 1'b0);
    block_protect_in   <= 1'b0;
    portion_protect_in <= 1'b1;
    wr(49152, 1'b0, 1'b0);
    size_sel <= 3'h1;
    wr(49152, 1'b0, 1'b1);
    size_sel           <= 3'h0;
    portion_protect_in <= 1'b0;
    program_select_in  <= 1'b0;
    wr(5, ~PAT[2], 1'b0);
    check("pin_idle", 8'h01, {7'h00, prog_data_in});
    program_select_in <= 1'b1;
    prog_drive_low    <= 1'b1;
    cyc(3);
    check("oc_drive", 8'h10, {3'h0, data_oe, 3'h0, data_out});
    cyc(2);
    check("pin_low", 8'h00, {7'h00, prog_data_in});
    prog_drive_low          <= 1'b0;
    program_mode_select_low <= 1'b1;
    wr(6, ~PAT[1], 1'b0);
    $display("test_prog done");
  endtask : test_prog
  task automatic test_follower();
    chip_select_low <= 1'b1;
    reset_oe_in     <= 1'b0;
    cyc(5);
    check("rst_float", 8'h00, {7'h00, data_oe});
    reset_oe_in <= 1'b1;
    cyc(4);
    check("follower", 8'h00, {7'h00, serial_bit_clock_oe});
    u_ldr.pulse(2);
    cyc(2);
    check("cs_high_float", 8'h00, {7'h00, data_oe});
    chip_select_low <= 1'b0;
    cyc(5);
    check("driver_on", 8'h01, {7'h00, data_oe});
    u_ldr.pulse(8);
    check("follower_bits", PAT, got);
    check("cascade_mid", 8'h01, {7'h00, cascade_out_low});
    chip_select_low <= 1'b1;
    cyc(4);
    check("standby", 8'h00, {7'h00, data_oe});
    $display("test_follower done");
  endtask : test_follower
  task automatic test_master();
    int n;
    logic [7:0] n0;
    chip_select_low <= 1'b0;
    reset_oe_in     <= 1'b0;
    cyc(5);
    check("master", 8'h01, {7'h00, serial_bit_clock_oe});
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      check("clk_rst_low", 8'h00, {7'h00, serial_bit_clock_out});
    end
    n0 = n_got;
    reset_oe_in <= 1'b1;
    n = 0;
    while (n_got !== n0 + 8'h08 && n < 200) begin
      cyc(1);
      n++;
    end
    if (n >= 200) begin
      fails++;
      complete_run();
    end
    check("master_bits", PAT, got);
    oe_active_high <= 1'b0;
    cyc(2);
    check("polarity", 8'h00, {6'h00, data_oe, serial_bit_clock_out});
    oe_active_high  <= 1'b1;
    chip_select_low <= 1'b1;
    cyc(4);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      check("clk_idle_low", 8'h00, {7'h00, serial_bit_clock_out});
    end
    $display("test_master done");
  endtask : test_master
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    fails = 0;
    n_tests = 0;
    {rst_n, chip_select_low, reset_oe_in, program_mode_select_low} = 4'h2;
    {program_select_in, portion_protect_in, block_protect_in} = 3'h4;
    {prog_drive_low, prog_wr_en, prog_wr_bit, last_d} = 4'h0;
    prog_wr_addr = '0;
    oe_active_high = 1'b1;
    size_sel = '0;
    cyc(5);
    test_por();
    test_prog();
    test_follower();
    test_master();
    complete_run();
  end
endmodule : serial_config_memory_readout_test
`default_nettype wire
